// file: hdl/adcr_pkg.sv
// Constants and carrier types of the converter control register block
package adcr_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] ADCR_OFS_RESULT_LOW = 8'h00;
    localparam logic [7:0] ADCR_OFS_RESULT_HIGH = 8'h04;
    localparam logic [7:0] ADCR_OFS_CONVERSION_CONTROL = 8'h08;
    localparam logic [7:0] ADCR_OFS_SOURCE_CLOCK = 8'h0C;
    localparam logic [7:0] ADCR_OFS_REFERENCE_CONTROL = 8'h10;
    localparam logic [7:0] ADCR_OFS_ANALOG_PIN_ENABLE = 8'h14;
    localparam logic [7:0] ADCR_OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADCR_OFS_IRQ_MASK = 8'h1C;
    // Field positions of conversion_control
    localparam int ADCR_POS_START = 7;
    localparam int ADCR_POS_BUSY = 6;
    localparam int ADCR_POS_ENABLE = 5;
    localparam int ADCR_POS_ALIGN = 4;
    localparam int ADCR_POS_CHAN = 0;
    // Field positions of source_and_clock_select
    localparam int ADCR_POS_SOURCE = 5;
    localparam int ADCR_POS_CLKDIV = 0;
    // Interrupt status bit positions
    localparam int ADCR_POS_IRQ_DONE = 0;
    localparam int ADCR_POS_IRQ_ABORT = 1;
    // Reset values
    localparam logic [7:0] ADCR_RST_CONVERSION_CONTROL = 8'h00;
    localparam logic [7:0] ADCR_RST_SOURCE_CLOCK = 8'h00;
    localparam logic [7:0] ADCR_RST_REFERENCE_CONTROL = 8'h00;
    localparam logic [7:0] ADCR_RST_ANALOG_PIN_ENABLE = 8'hFF;
    localparam logic [1:0] ADCR_RST_IRQ = 2'h0;
    // Source codes
    localparam logic [2:0] ADCR_SRC_EXT_A = 3'h0;
    localparam logic [2:0] ADCR_SRC_SUPPLY_FULL = 3'h1;
    localparam logic [2:0] ADCR_SRC_SUPPLY_HALF = 3'h2;
    localparam logic [2:0] ADCR_SRC_SUPPLY_QUARTER = 3'h3;
    localparam logic [2:0] ADCR_SRC_EXT_B = 3'h4;
    // Internal source route codes on the analog side
    localparam logic [1:0] ADCR_INT_NONE = 2'h0;
    localparam logic [1:0] ADCR_INT_FULL = 2'h1;
    localparam logic [1:0] ADCR_INT_HALF = 2'h2;
    localparam logic [1:0] ADCR_INT_QUARTER = 2'h3;
    // Conversion length in conversion clock ticks
    localparam logic [4:0] ADCR_CONV_TICKS = 5'h10;
    // AHB encodings
    localparam logic [1:0] ADCR_HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ADCR_ST_IDLE = 2'b00,
        ADCR_ST_CONV = 2'b01,
        ADCR_ST_LOAD = 2'b11
    } adcr_state_type;

    typedef struct packed {
        logic start;
        logic enable;
        logic align;
        logic [2:0] chan;
    } adcr_ctrl_type;

    typedef struct packed {
        logic [7:0] ext_connect;
        logic [1:0] int_source;
    } adcr_route_type;
endpackage

// file: hdl/adcr_top.sv
// Converter control, result registers and AHB-Lite slave
// Functional notes
// (R1) Result split over two bytes by alignment
// (R2) Unused result bits read as zero
// (R3) Enable low clears both result bytes
// (R4) Start low-high-low begins a conversion
// (R5) Start rising resets converter, clears busy
// (R6) Busy set at start fall, cleared done
// (R7) Busy flag ignores software writes
// (R8) Enable low switches the converter off
// (R9) Channel code picks input 0 to 7
// (R10) Source 000/100 external, else internal; codes 101 to 111 route nothing
// (R11) Source 001/010/011 supply by 1, 1/2, 1/4
// (R12) Internal source disconnects external channel
// (R13) Pin enable bit gives pin to converter
// (R14) Pin enable forces pull-high off
// (R15) Control bit 3 zero, reset all zero
// (R16) Completion raises the interrupt request flag
// (R17) Clock field divides by 1 to 128
// (R18) Fixed tick count, then load result and unbusy at one edge
// (R19) Start rising mid conversion aborts, no load
`timescale 1ns/1ps
module adcr_top
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Analog front end
    input wire logic [11:0] SAMPLE_DATA,
    output logic ADC_ON,
    output logic ADC_RESET,
    output logic CONV_TICK,
    output adcr_pkg::adcr_route_type ROUTE,
    output logic [7:0] REF_CTRL,
    // Pin sharing
    output logic [7:0] PIN_ANALOG,
    output logic [7:0] PULLUP_OFF,
    // Interrupt
    output logic IRQ
);
    import adcr_pkg::*;

    // Bus data-phase capture
    logic wr_pend_reg, wr_pend_next;
    logic rd_pend_reg, rd_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic take;

    assign take = HSEL && HREADY && (HTRANS == ADCR_HTRANS_NONSEQ);

    always_comb begin
        wr_pend_next = wr_pend_reg;
        rd_pend_next = rd_pend_reg;
        addr_next = addr_reg;
        if (HREADY) begin
            wr_pend_next = take && HWRITE;
            rd_pend_next = take && !HWRITE;
            if (take) begin
                addr_next = HADDR[7:0];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
        end
    end

    // Zero wait states; unmapped addresses read zero and drop writes
    assign HREADYOUT = 1'b1;
    assign HRESP = HRESP_OKAY;

    logic wr_en;
    logic [7:0] wdat;
    assign wr_en = wr_pend_reg && HREADY;
    assign wdat = HWDATA[7:0];

    // Software-written registers
    adcr_ctrl_type ctrl_reg, ctrl_next;
    logic [2:0] source_reg, source_next;
    logic [2:0] clkdiv_reg, clkdiv_next;
    logic [7:0] ref_reg, ref_next;
    logic [7:0] pin_en_reg, pin_en_next;
    logic [1:0] irq_mask_reg, irq_mask_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        source_next = source_reg;
        clkdiv_next = clkdiv_reg;
        ref_next = ref_reg;
        pin_en_next = pin_en_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_en) begin
            case (addr_reg)
                ADCR_OFS_CONVERSION_CONTROL: begin
                    // Busy and bit 3 positions are not stored
                    ctrl_next.start = wdat[ADCR_POS_START]; // (R7)
                    ctrl_next.enable = wdat[ADCR_POS_ENABLE];
                    ctrl_next.align = wdat[ADCR_POS_ALIGN];
                    ctrl_next.chan = wdat[ADCR_POS_CHAN +: 3];
                end
                ADCR_OFS_SOURCE_CLOCK: begin
                    source_next = wdat[ADCR_POS_SOURCE +: 3];
                    clkdiv_next = wdat[ADCR_POS_CLKDIV +: 3];
                end
                ADCR_OFS_REFERENCE_CONTROL: ref_next = wdat;
                ADCR_OFS_ANALOG_PIN_ENABLE: pin_en_next = wdat;
                ADCR_OFS_IRQ_MASK: irq_mask_next = wdat[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= adcr_ctrl_type'({ADCR_RST_CONVERSION_CONTROL[ADCR_POS_START],
                ADCR_RST_CONVERSION_CONTROL[ADCR_POS_ENABLE],
                ADCR_RST_CONVERSION_CONTROL[ADCR_POS_ALIGN],
                ADCR_RST_CONVERSION_CONTROL[ADCR_POS_CHAN +: 3]}); // (R15)
            source_reg <= ADCR_RST_SOURCE_CLOCK[7:5];
            clkdiv_reg <= ADCR_RST_SOURCE_CLOCK[2:0];
            ref_reg <= ADCR_RST_REFERENCE_CONTROL;
            pin_en_reg <= ADCR_RST_ANALOG_PIN_ENABLE;
            irq_mask_reg <= ADCR_RST_IRQ;
        end else begin
            ctrl_reg <= ctrl_next;
            source_reg <= source_next;
            clkdiv_reg <= clkdiv_next;
            ref_reg <= ref_next;
            pin_en_reg <= pin_en_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Start bit edges, seen as the stored value changes
    logic start_rise, start_fall;
    assign start_rise = ctrl_next.start && !ctrl_reg.start; // (R5)
    assign start_fall = !ctrl_next.start && ctrl_reg.start; // (R4)

    // Conversion clock divider
    logic [6:0] div_cnt_reg, div_cnt_next;
    logic [6:0] div_mask;
    logic tick;

    always_comb begin
        div_mask = 7'h00;
        case (clkdiv_reg)
            3'h0: div_mask = 7'h00;
            3'h1: div_mask = 7'h01;
            3'h2: div_mask = 7'h03;
            3'h3: div_mask = 7'h07;
            3'h4: div_mask = 7'h0F;
            3'h5: div_mask = 7'h1F;
            3'h6: div_mask = 7'h3F;
            default: div_mask = 7'h7F;
        endcase
    end

    // Divider restarts with each conversion so the first tick is a full period
    assign tick = (div_cnt_reg & div_mask) == div_mask; // (R17)

    always_comb begin
        div_cnt_next = 7'(div_cnt_reg + 7'h01);
        if (start_fall || tick) begin
            div_cnt_next = 7'h00;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_cnt_reg <= 7'h00;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    // Sample input from the analog side: two flip-flops first
    logic [11:0] samp_s1_reg, samp_s2_reg;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            samp_s1_reg <= 12'h000;
            samp_s2_reg <= 12'h000;
        end else begin
            samp_s1_reg <= SAMPLE_DATA;
            samp_s2_reg <= samp_s1_reg;
        end
    end

    // Conversion sequencer
    adcr_state_type state_reg, state_next;
    logic busy_reg, busy_next;
    logic [4:0] tick_cnt_reg, tick_cnt_next;
    logic [11:0] result_reg, result_next;
    logic ev_done, ev_abort;

    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        tick_cnt_next = tick_cnt_reg;
        result_next = result_reg;
        ev_done = 1'b0;
        ev_abort = 1'b0;
        case (state_reg)
            ADCR_ST_IDLE: begin
                if (start_fall && ctrl_next.enable) begin
                    state_next = ADCR_ST_CONV;
                    busy_next = 1'b1; // (R6)
                    tick_cnt_next = 5'h00;
                end
            end
            ADCR_ST_CONV: begin
                if (tick) begin
                    tick_cnt_next = 5'(tick_cnt_reg + 5'h01);
                end
                if (tick && tick_cnt_reg == 5'(ADCR_CONV_TICKS - 5'h01)) begin
                    state_next = ADCR_ST_LOAD; // (R18)
                end
            end
            ADCR_ST_LOAD: begin
                // Result and busy change at one edge, so idle never shows stale data
                result_next = samp_s2_reg; // (R18)
                state_next = ADCR_ST_IDLE;
                busy_next = 1'b0; // (R6)
                ev_done = 1'b1; // (R16)
            end
            default: begin
                state_next = ADCR_ST_IDLE;
                busy_next = 1'b0;
            end
        endcase
        // Reset request wins over the sequencer steps above; only enable low, below, overrides it
        if (start_rise) begin
            if (state_reg != ADCR_ST_IDLE) begin
                ev_abort = 1'b1; // (R19)
            end
            state_next = ADCR_ST_IDLE; // (R19)
            busy_next = 1'b0; // (R5)
            result_next = result_reg; // (R19)
            ev_done = 1'b0;
        end
        // Next value, so the sequencer stops at the same edge the converter goes off
        if (!ctrl_next.enable) begin
            state_next = ADCR_ST_IDLE; // (R8)
            busy_next = 1'b0;
            result_next = 12'h000; // (R3)
            ev_done = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ADCR_ST_IDLE;
            busy_reg <= 1'b0;
            tick_cnt_reg <= 5'h00;
            result_reg <= 12'h000;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            tick_cnt_reg <= tick_cnt_next;
            result_reg <= result_next;
        end
    end

    // Result views
    logic [7:0] res_low, res_high;
    always_comb begin
        if (ctrl_reg.align) begin
            res_high = {4'h0, result_reg[11:8]}; // (R1) (R2)
            res_low = result_reg[7:0]; // (R1)
        end else begin
            res_high = result_reg[11:4]; // (R1)
            res_low = {result_reg[3:0], 4'h0}; // (R2)
        end
    end

    // Interrupt status: set wins over the read clear
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic rd_stat;
    assign rd_stat = rd_pend_reg && HREADY && addr_reg == ADCR_OFS_IRQ_STATUS;

    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_stat) begin
            irq_stat_next = 2'h0;
        end
        if (ev_done) begin
            irq_stat_next[ADCR_POS_IRQ_DONE] = 1'b1; // (R16)
        end
        if (ev_abort) begin
            irq_stat_next[ADCR_POS_IRQ_ABORT] = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_stat_reg <= ADCR_RST_IRQ;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // Read mux in the data phase, fed only by flops
    logic [7:0] rdat;
    always_comb begin
        rdat = 8'h00;
        case (addr_reg)
            ADCR_OFS_RESULT_LOW: rdat = res_low;
            ADCR_OFS_RESULT_HIGH: rdat = res_high;
            ADCR_OFS_CONVERSION_CONTROL: begin
                rdat[ADCR_POS_START] = ctrl_reg.start;
                rdat[ADCR_POS_BUSY] = busy_reg; // (R7)
                rdat[ADCR_POS_ENABLE] = ctrl_reg.enable;
                rdat[ADCR_POS_ALIGN] = ctrl_reg.align;
                rdat[ADCR_POS_CHAN +: 3] = ctrl_reg.chan; // (R15)
            end
            ADCR_OFS_SOURCE_CLOCK: begin
                rdat[ADCR_POS_SOURCE +: 3] = source_reg;
                rdat[ADCR_POS_CLKDIV +: 3] = clkdiv_reg;
            end
            ADCR_OFS_REFERENCE_CONTROL: rdat = ref_reg;
            ADCR_OFS_ANALOG_PIN_ENABLE: rdat = pin_en_reg;
            ADCR_OFS_IRQ_STATUS: rdat = {6'h00, irq_stat_reg};
            ADCR_OFS_IRQ_MASK: rdat = {6'h00, irq_mask_reg};
            default: rdat = 8'h00;
        endcase
    end

    assign HRDATA = rd_pend_reg ? {24'h00_0000, rdat} : 32'h0000_0000;

    // Analog routing
    adcr_route_type route;
    always_comb begin
        route.ext_connect = 8'h00;
        route.int_source = ADCR_INT_NONE;
        case (source_reg)
            ADCR_SRC_EXT_A, ADCR_SRC_EXT_B: begin
                route.ext_connect = 8'(8'h01 << ctrl_reg.chan); // (R9) (R10)
            end
            // Channel field ignored for internal sources
            ADCR_SRC_SUPPLY_FULL: route.int_source = ADCR_INT_FULL; // (R11) (R12)
            ADCR_SRC_SUPPLY_HALF: route.int_source = ADCR_INT_HALF; // (R11) (R12)
            ADCR_SRC_SUPPLY_QUARTER: route.int_source = ADCR_INT_QUARTER; // (R11) (R12)
            default: route.int_source = ADCR_INT_NONE; // (R10) (R12)
        endcase
        if (!ctrl_reg.enable) begin
            route.ext_connect = 8'h00; // (R8)
            route.int_source = ADCR_INT_NONE;
        end
    end

    assign ROUTE = route;
    assign ADC_ON = ctrl_reg.enable; // (R8)
    // Held in reset while start stays high or the converter is off
    assign ADC_RESET = ctrl_reg.start || !ctrl_reg.enable; // (R5)
    assign CONV_TICK = tick && state_reg == ADCR_ST_CONV;
    assign REF_CTRL = ref_reg;
    assign PIN_ANALOG = pin_en_reg; // (R13)
    assign PULLUP_OFF = pin_en_reg; // (R14)
endmodule

// file: testbench/adcr_props.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module adcr_props
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Converter side
    input wire logic ADC_ON,
    input wire logic ADC_RESET,
    input wire logic CONV_TICK,
    input wire adcr_pkg::adcr_route_type ROUTE,
    input wire logic [7:0] PIN_ANALOG,
    input wire logic [7:0] PULLUP_OFF
);
    import adcr_pkg::*;

    logic rd_reg;
    logic rd_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Remember a read address phase so its data phase can be judged
    always_comb begin
        rd_next = HSEL && HREADY && (HTRANS == ADCR_HTRANS_NONSEQ) && !HWRITE;
        addr_next = HADDR[7:0];
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            rd_reg <= rd_next;
            addr_reg <= addr_next;
        end
    end

    a_pullup_follows: assert property (PULLUP_OFF == PIN_ANALOG)
        else $error("pull-high force off differs from pin analog enables");
    a_off_holds_reset: assert property (!ADC_ON |-> ADC_RESET)
        else $error("converter not held in reset while disabled");
    a_reset_no_tick: assert property (ADC_RESET |-> !CONV_TICK)
        else $error("conversion tick while converter in reset");
    a_bus_okay: assert property (HREADYOUT && (HRESP == HRESP_OKAY))
        else $error("slave not ready or response not okay");
    a_internal_isolates: assert property
        ((ROUTE.int_source != ADCR_INT_NONE) |-> (ROUTE.ext_connect == 8'h00))
        else $error("external channel connected with internal source");
    a_one_channel: assert property ($onehot0(ROUTE.ext_connect))
        else $error("more than one external channel connected");
    a_route_off: assert property (!ADC_ON |-> (ROUTE.ext_connect == 8'h00))
        else $error("channel routed while converter disabled");
    a_ctrl_gap_zero: assert property
        (rd_reg && (addr_reg == ADCR_OFS_CONVERSION_CONTROL) |-> (HRDATA[3] == 1'b0))
        else $error("control bit 3 read as one");
    a_result_cleared: assert property
        (rd_reg && (addr_reg == ADCR_OFS_RESULT_LOW || addr_reg == ADCR_OFS_RESULT_HIGH)
        && !ADC_ON && $past(!ADC_ON) |-> (HRDATA == 32'h0000_0000))
        else $error("result byte not zero while converter disabled");
endmodule

bind adcr_top adcr_props u_props (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ADC_ON(ADC_ON), .ADC_RESET(ADC_RESET),
    .CONV_TICK(CONV_TICK), .ROUTE(ROUTE), .PIN_ANALOG(PIN_ANALOG), .PULLUP_OFF(PULLUP_OFF));

// file: testbench/tb_adcr_top.sv
// Self-checking bench for the converter control register block
`timescale 1ns/1ps
module tb_adcr_top;
    import adcr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [11:0] sample = 12'hA5C;
    logic hreadyout, hresp, adc_on, adc_reset, conv_tick, irq;
    logic [7:0] ref_ctrl, pin_analog, pullup_off;
    adcr_route_type route;
    int n_mismatch = 0;
    int checks_done = 0;
    int ticks, cyc, i;
    // Rows: address, write value, expected read-back
    logic [7:0] row_a [6] = '{8'h10, 8'h14, 8'h0C, 8'h08, 8'h40, 8'h1C};
    logic [7:0] row_w [6] = '{8'hA5, 8'h3C, 8'hFF, 8'h5F, 8'hFF, 8'hFF};
    logic [7:0] row_e [6] = '{8'hA5, 8'h3C, 8'hE7, 8'h17, 8'h00, 8'h03};

    always #10 clk = ~clk;

    adcr_top DUT (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SAMPLE_DATA(sample),
        .ADC_ON(adc_on), .ADC_RESET(adc_reset), .CONV_TICK(conv_tick), .ROUTE(route),
        .REF_CTRL(ref_ctrl), .PIN_ANALOG(pin_analog), .PULLUP_OFF(pullup_off), .IRQ(irq));

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Phase ends at the rising edge where ready is seen high
    task wait_ready;
        int n;
        logic rdy;
        rdy = 1'b0;
        for (n = 0; n < 8 && !rdy; n++) begin
            @(posedge clk);
            rdy = hreadyout;
            r = hrdata;
        end
        if (!rdy) begin
            n_mismatch++;
            close_out();
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= ADCR_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e, input string msg);
        xfer(1'b0, a, 8'h00);
        check(r, {24'h00_0000, e}, msg);
    endtask

    // Count conversion ticks until the done interrupt shows
    task wait_irq;
        ticks = 0;
        for (cyc = 0; cyc < 400; cyc++) begin
            @(negedge clk);
            if (irq === 1'b1)
                break;
            ticks += int'(conv_tick);
        end
        @(posedge clk);
        if (cyc == 400) begin
            n_mismatch++;
            close_out();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h08, 8'h00, "control after reset");
        rd(8'h14, 8'hFF, "pin enables after reset");
        check(adc_on, 1'b0, "converter on after reset");
        for (i = 0; i < 6; i++) begin
            wr(row_a[i], row_w[i]);
            rd(row_a[i], row_e[i], "register row");
        end
        check(pullup_off, 8'h3C, "pull-high off");
        check(pin_analog, 8'h3C, "pin analog enables");
        check(ref_ctrl, 8'hA5, "reference control out");
        for (i = 0; i < 8; i++) begin
            wr(8'h0C, {i[2:0], 5'h00});
            wr(8'h08, {5'h04, i[2:0]});
            // Route follows the registers only after the write edge settles
            @(negedge clk);
            check(route.ext_connect, (i == 0 || i == 4) ? 8'h01 << i : 8'h00, "ext");
            check(route.int_source, (i > 0 && i < 4) ? i[1:0] : 2'h0, "internal");
            @(posedge clk);
        end
        wr(8'h0C, 8'h80);
        for (i = 0; i < 8; i++) begin
            wr(8'h08, {5'h04, i[2:0]});
            @(negedge clk);
            check(route.ext_connect, 8'h01 << i, "channel route");
            @(posedge clk);
        end
        wr(8'h0C, 8'h00);
        wr(8'h08, 8'hA0);
        wr(8'h08, 8'h20);
        wait_irq();
        check(ticks, 16, "tick count");
        rd(8'h08, 8'h20, "busy after done");
        rd(8'h04, 8'hA5, "high left");
        rd(8'h00, 8'hC0, "low left");
        rd(8'h18, 8'h01, "done status");
        rd(8'h18, 8'h00, "status cleared");
        wr(8'h08, 8'h30);
        rd(8'h04, 8'h0A, "high right");
        rd(8'h00, 8'h5C, "low right");
        sample <= 12'h3C7;
        wr(8'h0C, 8'h02);
        wr(8'h08, 8'hA0);
        wr(8'h08, 8'h20);
        rd(8'h08, 8'h60, "busy while converting");
        wr(8'h08, 8'hA0);
        rd(8'h08, 8'hA0, "busy after abort");
        check(adc_reset, 1'b1, "reset while start high");
        rd(8'h04, 8'hA5, "result kept on abort");
        wr(8'h1C, 8'h00);
        @(negedge clk);
        check(irq, 1'b0, "masked interrupt");
        @(posedge clk);
        rd(8'h18, 8'h02, "abort status");
        wr(8'h1C, 8'h01);
        wr(8'h08, 8'h20);
        wait_irq();
        check(ticks, 16, "divided tick count");
        check(cyc >= 60 && cyc <= 70, 1'b1, "divided span");
        rd(8'h04, 8'h3C, "new high");
        rd(8'h00, 8'h70, "new low");
        rd(8'h18, 8'h01, "done again");
        wr(8'h08, 8'h00);
        rd(8'h04, 8'h00, "high cleared");
        rd(8'h00, 8'h00, "low cleared");
        check(adc_reset, 1'b1, "held in reset when off");
        wr(8'h08, 8'h80);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'h00, "no start while disabled");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h14, 8'hFF, "pin enables after second reset");
        rd(8'h08, 8'h00, "control after second reset");
        close_out();
    end
endmodule
